// [hw/anp_pkg.sv]
// Purpose: shared constants and state layout of the next-page register pair
// Assumes: 5-bit management register address, 16-bit register data
// Notes:   every bit position and reset value used by the logic is named here
`default_nettype none

package anp_pkg;

    // bus geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int CODE_W = 11;
    localparam int EVT_W = 3;

    // register addresses
    localparam logic [ADDR_W-1:0] ADDR_PARTNER = 5'h05;
    localparam logic [ADDR_W-1:0] ADDR_EXP = 5'h06;
    localparam logic [ADDR_W-1:0] ADDR_NTX = 5'h07;
    localparam logic [ADDR_W-1:0] ADDR_ISTAT = 5'h10;
    localparam logic [ADDR_W-1:0] ADDR_IMASK = 5'h11;

    // expansion status field positions
    localparam int EXP_LOC_KNOWN = 6;
    localparam int EXP_LOC_SEL = 5;
    localparam int EXP_PDF = 4;
    localparam int EXP_LP_NP = 3;
    localparam int EXP_NP_CAP = 2;
    localparam int EXP_PAGE_RX = 1;
    localparam int EXP_LP_AN = 0;
    localparam int EXP_RSV_LSB = 7;

    // next-page transmit word and link code word field positions
    localparam int NTX_NP = 15;
    localparam int NTX_ACK = 14;
    localparam int NTX_MP = 13;
    localparam int NTX_COMPLY_ACKNOWLEDGE = 12;
    localparam int NTX_TOG = 11;

    // fixed values and reset values
    localparam logic LOC_KNOWN_VAL = 1'h1;
    localparam logic LOC_SEL_VAL = 1'h1;
    localparam logic NP_CAP_VAL = 1'h1;
    localparam logic NTX_MP_RST = 1'h1;
    localparam logic [CODE_W-1:0] NTX_CODE_RST = 11'h001;
    localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;
    localparam logic [EVT_W-1:0] EVT_ZERO = 3'h0;

    // interrupt event positions
    localparam int EVT_PAGE = 0;
    localparam int EVT_PDF = 1;
    localparam int EVT_LPAN = 2;

    // state of the register block, less the sticky interrupt status
    typedef struct packed {
        logic np;
        logic mp;
        logic comply_acknowledge;
        logic [CODE_W-1:0] code;
        logic ack;
        logic tog;
        logic parallel_detect_fault;
        logic lp_np;
        logic page_rx;
        logic lp_an;
        logic [EVT_W-1:0] imask;
        logic [DATA_W-1:0] lp_word;
        logic [DATA_W-1:0] rdata;
        logic [DATA_W-1:0] tx_word;
        logic tx_vld;
        logic irq;
    } anp_state_t;

endpackage

`default_nettype wire

// [hw/anp_evt_if.sv]
// Purpose: carries sticky event bits between the register block and holder
// Assumes: single clock domain
// Notes:   set and clear are one-cycle masks, q is the held status
`default_nettype none

interface anp_evt_if #(parameter int W = 3) ();
    logic [W-1:0] set; // event pulses
    logic [W-1:0] clr; // write-one-to-clear mask
    logic [W-1:0] q; // held status
    modport holder (input set, input clr, output q);
    modport user (output set, output clr, input q);
endinterface

`default_nettype wire

// [hw/anp_sticky.sv]
// Purpose: bank of sticky status bits, set by events, cleared by software
// Assumes: set and clear come from logic on the same clock
// Notes:   a set in the clear cycle wins, so no event is lost
`default_nettype none

module anp_sticky #(
    parameter int W = 3
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // event carrier
    anp_evt_if.holder evt
);

    typedef struct packed {
        logic [W-1:0] bits;
    } anp_stk_t;

    anp_stk_t s_r; // held bits
    anp_stk_t s_nxt; // next held bits

    ////////////////////////////////////////////////////////////////////////
    // next value: clear first, then set on top
    always_comb begin
        s_nxt = s_r;
        s_nxt.bits = (s_r.bits & ~evt.clr) | evt.set;
    end

    // register with synchronous reset
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign evt.q = s_r.bits;

    a_set_wins: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        |evt.set |=> ((evt.q & $past(evt.set)) == $past(evt.set)))
        else $error("sticky event lost");

endmodule // anp_sticky

`default_nettype wire

// [hw/anp_regs.sv]
// Purpose: expansion status and next-page transmit registers of autoneg
// Assumes: engine strobes arrive on mclk_i; plain register port
// Notes:   read data stand one cycle after the read strobe only
//
// Chosen here: the strobed register port.
`default_nettype none

// Overview of operation
// RULE_01 - expansion bits 15:7 ignore writes, read zero
// RULE_02 - expansion bit 6 reads one
// RULE_03 - expansion bit 5 reads one: pages in 8
// RULE_04 - parallel detect fault sets bit 4
// RULE_05 - partner next-page support sets bit 3
// RULE_06 - expansion bit 2 reads one
// RULE_07 - page received sets bit 1, read clears
// RULE_08 - partner autoneg support sets bit 0
// RULE_09 - transmit bit 15 writable, resets zero
// RULE_10 - transmit bit 14 acknowledges received word
// RULE_11 - transmit bit 13 writable, resets one
// RULE_12 - transmit bit 12 writable, resets zero
// RULE_13 - transmit bit 11 inverts previous toggle
// RULE_14 - code field writable, resets to null page
// RULE_15 - transmit register decoded at address 7
// RULE_16 - partner ability word decoded at address 5
// RULE_17 - send transmit word when both next-page capable
module anp_regs
    import anp_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // register port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    // autoneg engine side
    input wire logic page_rx_i,
    input wire logic [DATA_W-1:0] rx_word_i,
    input wire logic rx_is_next_i,
    input wire logic par_fault_i,
    input wire logic partner_an_i,
    input wire logic tx_taken_i,
    input wire logic an_restart_i,
    output logic [DATA_W-1:0] tx_word_o,
    output logic tx_valid_o,
    // interrupt
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // state and carriers

    anp_state_t s_r; // all registers of the block but the sticky status
    anp_state_t s_nxt; // their next values

    anp_evt_if #(.W(EVT_W)) evt_bus (); // sticky interrupt status link

    // decoded strobes
    logic wr_ntx; // write to transmit word
    logic wr_istat; // write-one-to-clear of interrupt status
    logic wr_imask; // write of interrupt mask
    logic rd_exp; // read of expansion status
    logic [DATA_W-1:0] exp_word; // assembled expansion word
    logic [DATA_W-1:0] ntx_word; // assembled transmit word

    ////////////////////////////////////////////////////////////////////////
    // address decode

    always_comb begin
        wr_ntx = wr_i && (addr_i == ADDR_NTX); // RULE_15
        wr_istat = wr_i && (addr_i == ADDR_ISTAT);
        wr_imask = wr_i && (addr_i == ADDR_IMASK);
        rd_exp = rd_i && (addr_i == ADDR_EXP);
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt events into the sticky bank

    always_comb begin
        evt_bus.set = EVT_ZERO;
        evt_bus.set[EVT_PAGE] = page_rx_i;
        evt_bus.set[EVT_PDF] = par_fault_i;
        evt_bus.set[EVT_LPAN] = partner_an_i;
        // only the low bits of the write data are status bits
        evt_bus.clr = wr_istat ? wdata_i[EVT_W-1:0] : EVT_ZERO;
    end

    // the status bank sits in its own module so the set-wins rule
    // is written and checked in one place only
    anp_sticky #(.W(EVT_W)) u_istat (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .evt(evt_bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // register views as software sees them

    always_comb begin
        exp_word = WORD_ZERO; // reserved bits stay zero // RULE_01
        exp_word[EXP_LOC_KNOWN] = LOC_KNOWN_VAL; // RULE_02
        exp_word[EXP_LOC_SEL] = LOC_SEL_VAL; // RULE_03
        exp_word[EXP_PDF] = s_r.parallel_detect_fault;
        exp_word[EXP_LP_NP] = s_r.lp_np;
        exp_word[EXP_NP_CAP] = NP_CAP_VAL; // RULE_06
        exp_word[EXP_PAGE_RX] = s_r.page_rx;
        exp_word[EXP_LP_AN] = s_r.lp_an;
    end

    always_comb begin
        ntx_word = WORD_ZERO;
        ntx_word[NTX_NP] = s_r.np;
        ntx_word[NTX_ACK] = s_r.ack;
        ntx_word[NTX_MP] = s_r.mp;
        ntx_word[NTX_COMPLY_ACKNOWLEDGE] = s_r.comply_acknowledge;
        ntx_word[NTX_TOG] = s_r.tog;
        ntx_word[CODE_W-1:0] = s_r.code;
    end

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        s_nxt = s_r;

        // software fields of the transmit word; ack and toggle ignore
        // writes because the engine owns them
        if (wr_ntx) begin
            s_nxt.np = wdata_i[NTX_NP]; // RULE_09
            s_nxt.mp = wdata_i[NTX_MP]; // RULE_11
            s_nxt.comply_acknowledge = wdata_i[NTX_COMPLY_ACKNOWLEDGE]; // RULE_12
            s_nxt.code = wdata_i[CODE_W-1:0]; // RULE_14
        end

        // interrupt mask
        if (wr_imask) begin
            s_nxt.imask = wdata_i[EVT_W-1:0];
        end

        // a restart drops what was learnt about the partner
        if (an_restart_i) begin
            s_nxt.lp_np = 1'h0;
            s_nxt.lp_an = 1'h0;
            s_nxt.ack = 1'h0;
            s_nxt.tog = 1'h0;
            s_nxt.parallel_detect_fault = 1'h0;
        end

        // toggle follows each word the engine sent
        if (tx_taken_i && !an_restart_i) begin
            s_nxt.tog = ~s_r.tog; // RULE_13
            s_nxt.ack = 1'h0;
        end

        // page received: acknowledge it and learn the partner
        // placed after the clears so a set in the same cycle wins
        if (page_rx_i) begin
            s_nxt.ack = 1'h1; // RULE_10
            if (rx_word_i[NTX_NP]) begin
                s_nxt.lp_np = 1'h1; // RULE_05
            end
            // base pages only; next pages belong to register 8
            if (!rx_is_next_i) begin
                s_nxt.lp_word = rx_word_i; // RULE_16
            end
        end

        // fault and partner detection are sticky until restart
        if (par_fault_i) begin
            s_nxt.parallel_detect_fault = 1'h1; // RULE_04
        end
        if (partner_an_i) begin
            s_nxt.lp_an = 1'h1; // RULE_08
        end

        // clear-on-read, but a new page in that cycle is kept
        s_nxt.page_rx = (s_r.page_rx && !rd_exp) || page_rx_i; // RULE_07

        // read data for the cycle after the strobe only
        s_nxt.rdata = WORD_ZERO;
        if (rd_i) begin
            unique case (addr_i)
                ADDR_PARTNER: s_nxt.rdata = s_r.lp_word; // RULE_16
                ADDR_EXP: s_nxt.rdata = exp_word;
                ADDR_NTX: s_nxt.rdata = ntx_word; // RULE_15
                ADDR_ISTAT: begin
                    s_nxt.rdata[EVT_W-1:0] = evt_bus.q;
                end
                ADDR_IMASK: begin
                    s_nxt.rdata[EVT_W-1:0] = s_r.imask;
                end
                default: s_nxt.rdata = WORD_ZERO; // unmapped reads zero
            endcase
        end

        // outgoing link code word built from the next values so the
        // engine sees a fresh write one cycle after it
        s_nxt.tx_word = WORD_ZERO;
        s_nxt.tx_word[NTX_NP] = s_nxt.np;
        s_nxt.tx_word[NTX_ACK] = s_nxt.ack;
        s_nxt.tx_word[NTX_MP] = s_nxt.mp;
        s_nxt.tx_word[NTX_COMPLY_ACKNOWLEDGE] = s_nxt.comply_acknowledge;
        s_nxt.tx_word[NTX_TOG] = s_nxt.tog;
        s_nxt.tx_word[CODE_W-1:0] = s_nxt.code;
        // no valid while the partner is unknown: the engine would
        // otherwise send a next page that nobody asked for
        s_nxt.tx_vld = NP_CAP_VAL && s_nxt.lp_np; // RULE_17

        // level interrupt; one cycle behind the status bank
        s_nxt.irq = |(evt_bus.q & s_r.imask);
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            // mp and code have non-zero defaults, so the transmit
            // word flop is seeded to match them
            s_r <= '0;
            s_r.mp <= NTX_MP_RST; // RULE_11
            s_r.code <= NTX_CODE_RST; // RULE_14
            s_r.tx_word <= {WORD_ZERO[DATA_W-1:NTX_MP+1], NTX_MP_RST,
                            WORD_ZERO[NTX_COMPLY_ACKNOWLEDGE:CODE_W], NTX_CODE_RST};
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flops
    assign rdata_o = s_r.rdata;
    assign tx_word_o = s_r.tx_word;
    assign tx_valid_o = s_r.tx_vld;
    assign irq_o = s_r.irq;

    ////////////////////////////////////////////////////////////////////////
    // checks

    // all checks share the one clock and sleep through reset
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    // register port: reserved and fixed expansion bits
    a_resv_bits_zero: assert property ( // RULE_01
        rd_exp |=> (rdata_o[DATA_W-1:EXP_RSV_LSB] == '0))
        else $error("reserved expansion bits not zero");

    a_fixed_ones: assert property ( // RULE_02
        rd_exp |=> (rdata_o[EXP_LOC_KNOWN] && rdata_o[EXP_LOC_SEL]
                    && rdata_o[EXP_NP_CAP]))
        else $error("fixed expansion bits not one");

    // engine side: learnt bits and the page handshake
    a_fault_sticks: assert property ( // RULE_04
        par_fault_i ##1 (!an_restart_i) [*2] |=> s_r.parallel_detect_fault)
        else $error("parallel fault not held");

    a_partner_np: assert property ( // RULE_05
        page_rx_i && rx_word_i[NTX_NP] |=> s_r.lp_np && tx_valid_o)
        else $error("partner next page not learnt");

    a_page_cor: assert property ( // RULE_07
        rd_exp && !page_rx_i |=> !s_r.page_rx)
        else $error("page flag not cleared by read");

    a_page_set: assert property ( // RULE_07
        page_rx_i ##1 rd_exp |=> rdata_o[EXP_PAGE_RX])
        else $error("page flag not seen by read");

    a_ack_drive: assert property ( // RULE_10
        page_rx_i |=> tx_word_o[NTX_ACK])
        else $error("ack not driven after page");

    a_toggle_flip: assert property ( // RULE_13
        tx_taken_i && !an_restart_i |=> (s_r.tog != $past(s_r.tog)))
        else $error("toggle did not invert");

    a_ntx_write: assert property ( // RULE_09
        wr_ntx ##1 !wr_i ##1 rd_i && (addr_i == ADDR_NTX)
        |=> (rdata_o[NTX_NP] == $past(wdata_i[NTX_NP], 3))
            && (rdata_o[CODE_W-1:0] == $past(wdata_i[CODE_W-1:0], 3)))
        else $error("transmit word write lost");

    // interrupt level follows the unmasked status one cycle later
    a_irq_level: assert property (
        ((evt_bus.q & s_r.imask) != EVT_ZERO) |=> irq_o)
        else $error("interrupt not raised");

    a_irq_quiet: assert property (
        ((evt_bus.q & s_r.imask) == EVT_ZERO) |=> !irq_o)
        else $error("interrupt raised while all masked");

    // ack drops once the engine has sent its word, unless a page lands
    a_ack_clear: assert property ( // RULE_10
        tx_taken_i && !page_rx_i |=> !tx_word_o[NTX_ACK])
        else $error("ack not cleared after send");

    // software writes never move the engine-owned ack and toggle
    a_ro_ignored: assert property ( // RULE_13
        wr_ntx && !page_rx_i && !tx_taken_i && !an_restart_i
        |=> $stable(s_r.ack) && $stable(s_r.tog))
        else $error("read-only transmit bits written");

    // toggle only moves on a sent word or a restart
    a_tog_hold: assert property ( // RULE_13
        !tx_taken_i && !an_restart_i |=> $stable(s_r.tog))
        else $error("toggle moved without a send");

    // message page and comply bits land one cycle after the write
    a_mp_write: assert property ( // RULE_11
        wr_ntx |=> (tx_word_o[NTX_MP] == $past(wdata_i[NTX_MP]))
            && (tx_word_o[NTX_COMPLY_ACKNOWLEDGE] == $past(wdata_i[NTX_COMPLY_ACKNOWLEDGE])))
        else $error("message page bits not written");

    // base pages are stored, next pages leave the word alone
    a_base_stored: assert property ( // RULE_16
        page_rx_i && !rx_is_next_i |=> (s_r.lp_word == $past(rx_word_i)))
        else $error("base page not stored");

    a_next_kept: assert property ( // RULE_16
        page_rx_i && rx_is_next_i |=> $stable(s_r.lp_word))
        else $error("next page overwrote partner word");

    // a restart with no event beside it forgets the partner
    a_restart_clears: assert property ( // RULE_05
        an_restart_i && !page_rx_i && !par_fault_i && !partner_an_i
        |=> !s_r.lp_np && !s_r.lp_an && !s_r.parallel_detect_fault)
        else $error("restart left partner state");

    // partner autoneg detection is seen the next cycle
    a_an_sticks: assert property ( // RULE_08
        partner_an_i |=> s_r.lp_an)
        else $error("partner autoneg not learnt");

    // read data bus idles at zero outside the answer cycle
    a_rd_idle_zero: assert property (
        !rd_i |=> (rdata_o == WORD_ZERO))
        else $error("read data outside answer cycle");

    c_page_then_read: cover property (page_rx_i ##[1:4] rd_exp);
    c_write_then_send: cover property (wr_ntx ##[1:8] tx_taken_i);
    c_irq_rise: cover property ($rose(irq_o));
    c_restart_page: cover property (an_restart_i && page_rx_i);
    c_next_page: cover property (page_rx_i && rx_is_next_i);

endmodule // anp_regs

`default_nettype wire

// [testbench/anp_partner.sv]
// Purpose: link partner stand-in that hands pages to the register block
// Assumes: bench commands are one-cycle pulses on mclk_i
// Notes:   idle word lines show the inverse of the last value, not a hold
`default_nettype none

module anp_partner
    import anp_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // bench commands
    input wire logic snd_i,
    input wire logic [DATA_W-1:0] wrd_i,
    input wire logic nxt_i,
    input wire logic take_i,
    // design side
    input wire logic [DATA_W-1:0] tx_word_i,
    input wire logic tx_valid_i,
    output logic page_rx_o,
    output logic [DATA_W-1:0] rx_word_o,
    output logic rx_is_next_o,
    output logic tx_taken_o,
    output logic [DATA_W-1:0] sent_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // page pulses; word lines only mean something beside the pulse
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            page_rx_o <= 1'h0;
            rx_word_o <= WORD_ZERO;
            rx_is_next_o <= 1'h0;
            tx_taken_o <= 1'h0;
            sent_o <= WORD_ZERO;
        end else begin
            page_rx_o <= snd_i;
            rx_word_o <= snd_i ? wrd_i : ~rx_word_o;
            rx_is_next_o <= snd_i ? nxt_i : ~rx_is_next_o;
            // a word is only taken while both ends can page
            tx_taken_o <= take_i & tx_valid_i;
            if (take_i & tx_valid_i) begin
                sent_o <= tx_word_i;
            end
        end
    end
endmodule // anp_partner

`default_nettype wire

// [testbench/tb_anp_regs.sv]
// Purpose: self-checking bench of the next-page register pair
// Assumes: plain register port, read data one cycle after the strobe
// Notes:   expectations come from bench functions, never from the design
`default_nettype none

module tb_anp_regs
    import anp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // design and partner signals
    logic mclk_i, rstn_i, wr_i, rd_i, par_fault_i, partner_an_i, an_restart_i;
    logic page_rx, rx_is_next, tx_taken, tx_valid_o, irq_o, snd, nxt, take;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i, rdata_o, rx_word, tx_word_o, wrd, sent, w;
    int bad_count, comparisons, seed;

    anp_regs dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .page_rx_i(page_rx), .rx_word_i(rx_word), .rx_is_next_i(rx_is_next),
        .par_fault_i(par_fault_i), .partner_an_i(partner_an_i),
        .tx_taken_i(tx_taken), .an_restart_i(an_restart_i),
        .tx_word_o(tx_word_o), .tx_valid_o(tx_valid_o), .irq_o(irq_o));

    anp_partner far (.mclk_i(mclk_i), .rstn_i(rstn_i), .snd_i(snd),
        .wrd_i(wrd), .nxt_i(nxt), .take_i(take), .tx_word_i(tx_word_o),
        .tx_valid_i(tx_valid_o), .page_rx_o(page_rx), .rx_word_o(rx_word),
        .rx_is_next_o(rx_is_next), .tx_taken_o(tx_taken), .sent_o(sent));

    ////////////////////////////////////////////////////////////////////////
    // expected words
    function automatic logic [DATA_W-1:0] f_exp(input logic parallel_detect_fault, lpnp,
        prx, lpan);
        return {9'h000, LOC_KNOWN_VAL, LOC_SEL_VAL, parallel_detect_fault, lpnp, NP_CAP_VAL,
            prx, lpan};
    endfunction

    // transmit word: software fields plus engine-owned ack and toggle
    function automatic logic [DATA_W-1:0] f_ntx(input logic [DATA_W-1:0] v,
        input logic ack, tog);
        return {v[15], ack, v[13:12], tog, v[10:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // compare and report
    task automatic chk(input logic [DATA_W-1:0] seen,
        input logic [DATA_W-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // bus cycles: strobe for one cycle, settle past the taking edge
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'h1;
        @(posedge mclk_i);
        wr_i <= 1'h0;
        #1;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'h1;
        @(posedge mclk_i);
        rd_i <= 1'h0;
        #1;
        chk(rdata_o, exp);
    endtask

    // engine events, all one-cycle pulses
    task automatic evt(input logic f, input logic a, input logic r);
        @(posedge mclk_i);
        par_fault_i <= f;
        partner_an_i <= a;
        an_restart_i <= r;
        @(posedge mclk_i);
        par_fault_i <= 1'h0;
        partner_an_i <= 1'h0;
        an_restart_i <= 1'h0;
        tick(3);
    endtask

    task automatic page(input logic [DATA_W-1:0] v, input logic n);
        @(posedge mclk_i);
        snd <= 1'h1;
        wrd <= v;
        nxt <= n;
        @(posedge mclk_i);
        snd <= 1'h0;
        tick(3);
        #1;
    endtask

    task automatic take_word;
        @(posedge mclk_i);
        take <= 1'h1;
        @(posedge mclk_i);
        take <= 1'h0;
        tick(3);
        #1;
    endtask

    // bounded wait for the interrupt level
    task automatic wait_irq(input logic exp);
        int n;
        n = 0;
        while (irq_o !== exp && n < 8) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        chk({15'h0000, irq_o}, {15'h0000, exp});
        if (irq_o !== exp) end_sim;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        mclk_i = 1'h0;
        forever #50 mclk_i = ~mclk_i;
    end

    initial begin
        repeat (20000) @(posedge mclk_i);
        bad_count++;
        end_sim;
    end

    // main sequence
    initial begin
        seed = 36379;
        {rstn_i, wr_i, rd_i, par_fault_i, partner_an_i} = 5'h00;
        {an_restart_i, snd, nxt, take} = 4'h0;
        addr_i = 5'h00;
        wdata_i = WORD_ZERO;
        wrd = WORD_ZERO;
        bad_count = 0;
        comparisons = 0;
        tick(3);
        rstn_i <= 1'h1;
        #1;
        // reset values and fixed bits
        chk(tx_word_o, 16'h2001);
        chk({15'h0000, tx_valid_o}, WORD_ZERO);
        rd(ADDR_EXP, f_exp(0, 0, 0, 0));
        rd(ADDR_NTX, 16'h2001);
        @(posedge mclk_i);
        #1;
        chk(rdata_o, WORD_ZERO);
        rd(ADDR_PARTNER, WORD_ZERO);
        rd(5'h1F, WORD_ZERO);
        wr(ADDR_EXP, 16'hFFFF);
        rd(ADDR_EXP, f_exp(0, 0, 0, 0));
        // transmit word: corners then random values
        for (int i = 0; i < 12; i++) begin
            w = (i == 0) ? 16'hFFFF : (i == 1) ? WORD_ZERO
                : 16'($random(seed));
            wr(ADDR_NTX, w);
            chk(tx_word_o, f_ntx(w, 0, 0));
            rd(ADDR_NTX, f_ntx(w, 0, 0));
        end
        wr(5'h1F, 16'h1234);
        rd(ADDR_NTX, f_ntx(w, 0, 0));
        // base page with next-page request, page interrupt enabled
        wr(ADDR_NTX, 16'hA005);
        wr(ADDR_IMASK, 16'h0001);
        page(16'h8421, 1'h0);
        chk(tx_word_o, f_ntx(16'hA005, 1, 0));
        chk({15'h0000, tx_valid_o}, 16'h0001);
        wait_irq(1'h1);
        rd(ADDR_PARTNER, 16'h8421);
        rd(ADDR_ISTAT, 16'h0001);
        rd(ADDR_EXP, f_exp(0, 1, 1, 0));
        rd(ADDR_EXP, f_exp(0, 1, 0, 0));
        wr(ADDR_ISTAT, 16'h0001);
        wait_irq(1'h0);
        take_word;
        chk(sent, f_ntx(16'hA005, 1, 0));
        chk(tx_word_o, f_ntx(16'hA005, 0, 1));
        // a next page must not land in the partner ability word
        page(16'h0123, 1'h1);
        rd(ADDR_PARTNER, 16'h8421);
        take_word;
        chk(tx_word_o, f_ntx(16'hA005, 0, 0));
        // fault and partner autoneg while masked, then unmasked
        wr(ADDR_ISTAT, 16'h0007);
        wr(ADDR_IMASK, WORD_ZERO);
        evt(1'h1, 1'h1, 1'h0);
        rd(ADDR_ISTAT, 16'h0006);
        chk({15'h0000, irq_o}, WORD_ZERO);
        rd(ADDR_EXP, f_exp(1, 1, 1, 1));
        wr(ADDR_IMASK, 16'h0006);
        wait_irq(1'h1);
        wr(ADDR_ISTAT, 16'h0007);
        wait_irq(1'h0);
        rd(ADDR_IMASK, 16'h0006);
        // restart forgets what was learnt of the partner
        // restart beside new events: the events win
        evt(1'h1, 1'h1, 1'h1);
        rd(ADDR_EXP, f_exp(1, 0, 0, 1));
        evt(1'h0, 1'h0, 1'h1);
        rd(ADDR_EXP, f_exp(0, 0, 0, 0));
        chk({15'h0000, tx_valid_o}, WORD_ZERO);
        // reset in mid-run brings back every default
        @(posedge mclk_i);
        rstn_i <= 1'h0;
        tick(2);
        rstn_i <= 1'h1;
        #1;
        chk(tx_word_o, 16'h2001);
        chk({15'h0000, irq_o}, WORD_ZERO);
        rd(ADDR_ISTAT, WORD_ZERO);
        rd(ADDR_NTX, 16'h2001);
        end_sim;
    end
endmodule // tb_anp_regs

`default_nettype wire
